// file: verilog/dtc_debug_trace.sv
// trace line counter, full flag and state1 next-state sequencer
// assumes comparator match inputs are already gated by their enables
//
// Function
// - full flag sets after 64 stored lines; then all 64 lines valid
// - full flag clears on arm write and power-on reset only
// - full flag mirrored at status register bit 7
// - six-bit count in bits 5..0 of valid 20-bit lines
// - count wrap to zero sets full; counting goes on in end alignment
// - count clears on arm write and power-on reset, kept otherwise
// - trace buffer reads never decrement the count
// - count register readable anytime, writes ignored
// - full, count zero, begin alignment: arm clears, session ends
// - full with nonzero count: oldest lines overwritten, 64 valid
// - view select picks state1, state2, state3 or match flags view
// - state1 code read only in view 00, written there when disarmed
// - state1 code in bits 2..0, resets zero, upper bits read zero
// - codes 000..011 map matches to final, state3, state2, state2
// - codes 100..111 map match pairs as tabled; 111 ignores match2
// - simultaneous matches: lowest numbered channel wins
// - a match targeting final beats all other matches
// - align bit zero is end alignment, one is begin alignment
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps

module dtc_debug_trace
  import dtc_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    sysRst_n,
  input  wire logic [9:0]              wbAdr,
  input  wire logic [31:0]             wbDatI,
  output logic      [31:0]             wbDatO,
  input  wire logic                    wbWe,
  input  wire logic [3:0]              wbSel,
  input  wire logic                    wbCyc,
  input  wire logic                    wbStb,
  output logic                         wbAck,
  input  wire logic [2:0]              matchIn,
  input  wire logic                    lineStored,
  output logic                         armed,
  output logic                         traceFull,
  output logic      [dtc_pkg::COUNT_W-1:0] lineCount,
  output dtc_pkg::dtc_state_e          seqState
);
  import dtc_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic                 ackReg;
  logic [31:0]          datReg;
  logic                 armReg;
  logic [1:0]           viewReg;
  logic                 alignReg;
  logic [CODE_W-1:0]    codeReg;
  logic [COUNT_W-1:0]   countReg;
  logic [COUNT_W-1:0]   countNext;
  logic                 fullReg;
  logic                 fullNext;
  logic                 wrapEvt;
  logic                 endSession;
  dtc_state_e           stateReg;
  dtc_state_e           stateNext;
  logic [7:0]           regIdx;
  logic                 wrTake;
  logic                 armWr;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // one accepted write aimed at a given register index
  function automatic logic wrHit(
    input logic       take,
    input logic [7:0] idx,
    input logic [7:0] want
  );
    return take && (idx == want);
  endfunction : wrHit

  assign regIdx = wbAdr[9:2];
  // write lands on the edge where the master sees ack
  assign wrTake = wbCyc & wbStb & wbWe & ackReg & wbSel[0];
  // an arm write during system reset is dropped like any other write
  assign armWr  = wrHit(wrTake, regIdx, IDX_CONTROL_ONE)
                  & sysRst_n & wbDatI[ARM_BIT];

  // ----------------------------------------------------------------
  // state1 next-state function
  // ----------------------------------------------------------------
  function automatic dtc_state_e chanTarget(
    input logic [CODE_W-1:0] code,
    input int                chan
  );
    dtc_state_e t;
    t = ST_DISARMED;
    case (code)
      3'h0: t = ST_FINAL;
      3'h1: if (chan == 1) t = ST_THREE;
      3'h2: if (chan == 2) t = ST_TWO;
      3'h3: if (chan == 1) t = ST_TWO;
      3'h4: begin
        if (chan == 0) t = ST_TWO;
        if (chan == 1) t = ST_THREE;
      end
      3'h5: begin
        if (chan == 1) t = ST_THREE;
        if (chan == 0) t = ST_FINAL;
      end
      3'h6: begin
        if (chan == 0) t = ST_TWO;
        if (chan == 2) t = ST_THREE;
      end
      3'h7: if (chan != 2) t = ST_TWO;
      default: t = ST_DISARMED;
    endcase
    return t;
  endfunction : chanTarget

  function automatic dtc_state_e state1Next(
    input logic [CODE_W-1:0] code,
    input logic [2:0]        m
  );
    dtc_state_e pick;
    dtc_state_e t;
    logic       hitFinal;
    pick     = ST_ONE;
    hitFinal = 1'b0;
    // scan high to low so the lowest channel lands last
    for (int c = 2; c >= 0; c--) begin
      t = chanTarget(code, c);
      if (m[c] && t != ST_DISARMED) begin
        pick = t;
        if (t == ST_FINAL) hitFinal = 1'b1;
      end
    end
    if (hitFinal) pick = ST_FINAL;
    return pick;
  endfunction : state1Next

  // ----------------------------------------------------------------
  // trace counter and full flag
  // ----------------------------------------------------------------
  // lineStored never decrements; reads of trace data do not touch it
  // lines stored while system reset is low are dropped; the count holds
  assign wrapEvt = armReg & sysRst_n & lineStored
                   & (countReg == COUNT_W'(TRACE_LINES - 1));
  // begin alignment stops once the buffer has wrapped to zero
  assign endSession = fullReg & (countReg == COUNT_RESET)
                      & (alignReg == ALIGN_BEGIN) & armReg;

  always_comb begin
    countNext = countReg;
    fullNext  = fullReg;
    if (armWr) begin
      countNext = COUNT_RESET;
      fullNext  = 1'b0;
    end else if (armReg && sysRst_n && lineStored && !endSession) begin
      countNext = countReg + 6'h01;
    end
    // a wrap in the clearing cycle is not lost
    if (wrapEvt && !endSession) fullNext = 1'b1;
  end

  // power-on reset only; other resets keep the pre-reset count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      countReg <= COUNT_RESET;
      fullReg  <= 1'b0;
    end else begin
      countReg <= countNext;
      fullReg  <= fullNext;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n || !sysRst_n) begin
      armReg   <= 1'b0;
      viewReg  <= VIEW_STATE1;
      alignReg <= ALIGN_END;
      codeReg  <= CODE_RESET;
    end else begin
      if (wrHit(wrTake, regIdx, IDX_CONTROL_ONE)) begin
        armReg  <= wbDatI[ARM_BIT];
        viewReg <= wbDatI[VIEW_LSB +: 2];
      end else if (endSession) begin
        armReg <= 1'b0;
      end
      if (wrHit(wrTake, regIdx, IDX_TRACE_CTRL) && !armReg) begin
        alignReg <= wbDatI[ALIGN_BIT];
      end
      if (wrHit(wrTake, regIdx, IDX_STATE_VIEW)
          && viewReg == VIEW_STATE1 && !armReg) begin
        codeReg <= wbDatI[CODE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_DISARMED: if (armWr) stateNext = ST_ONE;
      ST_ONE:      stateNext = state1Next(codeReg, matchIn);
      ST_TWO:      stateNext = stateReg;
      ST_THREE:    stateNext = stateReg;
      ST_FINAL:    stateNext = stateReg;
      default:     stateNext = ST_DISARMED;
    endcase
    if (armWr) stateNext = ST_ONE;
    else if (!armReg || endSession) stateNext = ST_DISARMED;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !sysRst_n) begin
      stateReg <= ST_DISARMED;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ackReg <= 1'b0;
      datReg <= 32'h0000_0000;
    end else begin
      ackReg <= wbCyc & wbStb & ~ackReg;
      datReg <= 32'h0000_0000;
      if (wbCyc && wbStb && !ackReg && !wbWe) begin
        case (regIdx)
          IDX_CONTROL_ONE: begin
            datReg[ARM_BIT]         <= armReg;
            datReg[VIEW_LSB +: 2]   <= viewReg;
          end
          IDX_STATUS: begin
            datReg[FULL_BIT]        <= fullReg;
            datReg[2:0]             <= 3'(stateReg);
          end
          IDX_TRACE_CTRL: datReg[ALIGN_BIT] <= alignReg;
          IDX_TRACE_COUNT: begin
            datReg[FULL_BIT]        <= fullReg;
            datReg[COUNT_W-1:0]     <= countReg;
          end
          IDX_STATE_VIEW: begin
            // other views belong to neighbouring logic; read as zero
            if (viewReg == VIEW_STATE1)
              datReg[CODE_W-1:0] <= codeReg;
          end
          default: datReg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wbAck     = ackReg;
  assign wbDatO    = datReg;
  assign armed     = armReg;
  assign traceFull = fullReg;
  assign lineCount = countReg;
  assign seqState  = stateReg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_full_on_wrap: assert property (
    wrapEvt && !endSession |=> fullReg)
    else $error("full flag missed a wrap");
  chk_arm_clears: assert property (
    armWr && !wrapEvt |=> !fullReg && countReg == 6'h00)
    else $error("arm write did not clear count and full");
  chk_sysrst_keeps: assert property (
    !sysRst_n |=> $stable(countReg) && $stable(fullReg))
    else $error("system reset changed count");
  chk_count_step: assert property (
    armReg && sysRst_n && lineStored && !armWr && !endSession
    |=> countReg == $past(countReg) + 6'h01)
    else $error("count did not step per line");
  chk_count_hold: assert property (
    !lineStored && !armWr |=> $stable(countReg))
    else $error("count moved without a stored line");
  chk_begin_stop: assert property (
    endSession && !armWr && sysRst_n
    |=> !armReg && stateReg == ST_DISARMED)
    else $error("begin alignment did not end session");
  chk_final_prio: assert property (
    stateReg == ST_ONE && armReg && !armWr && !endSession && sysRst_n
    && codeReg == 3'h5 && matchIn[0] |=> stateReg == ST_FINAL)
    else $error("final target lost priority");
  chk_low_chan: assert property (
    stateReg == ST_ONE && armReg && !armWr && !endSession && sysRst_n
    && codeReg == 3'h4 && matchIn[1:0] == 2'b11 |=> stateReg == ST_TWO)
    else $error("lowest channel did not win");
  chk_code_lock: assert property (
    armReg && sysRst_n |=> $stable(codeReg))
    else $error("state1 code written while armed");
  chk_ack_pulse: assert property (
    wbCyc && wbStb && !ackReg |=> ackReg ##1 !ackReg)
    else $error("ack not a single cycle answer");

  // bus reads: data stands in the cycle after the request edge
  chk_status_full: assert property (
    wbCyc && wbStb && !ackReg && !wbWe && regIdx == IDX_STATUS
    |=> wbDatO[FULL_BIT] == $past(fullReg))
    else $error("status bit 7 does not mirror full flag");
  chk_count_read: assert property (
    wbCyc && wbStb && !ackReg && !wbWe && regIdx == IDX_TRACE_COUNT
    |=> wbDatO[COUNT_W-1:0] == $past(countReg)
        && wbDatO[FULL_BIT] == $past(fullReg))
    else $error("count register read wrong");
  chk_count_ro: assert property (
    wrTake && regIdx == IDX_TRACE_COUNT && !lineStored
    |=> $stable(countReg) && $stable(fullReg))
    else $error("write to count register took effect");
  chk_view_zero: assert property (
    wbCyc && wbStb && !ackReg && !wbWe && regIdx == IDX_STATE_VIEW
    && viewReg != VIEW_STATE1 |=> wbDatO == 32'h0000_0000)
    else $error("hidden banked view did not read zero");
  chk_code_read: assert property (
    wbCyc && wbStb && !ackReg && !wbWe && regIdx == IDX_STATE_VIEW
    && viewReg == VIEW_STATE1
    |=> wbDatO == {29'h0000_0000, $past(codeReg)})
    else $error("state1 code read wrong");

  // trace counter and system reset disarm
  chk_full_sticky: assert property (
    fullReg && !armWr |=> fullReg)
    else $error("full flag dropped without an arm write");
  chk_wrap_zero: assert property (
    wrapEvt && !armWr |=> countReg == COUNT_RESET)
    else $error("count did not wrap to zero");
  chk_sys_disarm: assert property (
    !sysRst_n |=> !armReg && stateReg == ST_DISARMED)
    else $error("system reset did not disarm");

  // sequencer, register write locks and state1 code write
  chk_any_final: assert property (
    stateReg == ST_ONE && armReg && !armWr && !endSession && sysRst_n
    && codeReg == 3'h0 && matchIn != 3'h0 |=> stateReg == ST_FINAL)
    else $error("code zero match did not reach final");
  chk_m2_ignored: assert property (
    stateReg == ST_ONE && armReg && !armWr && !endSession && sysRst_n
    && codeReg == 3'h7 && matchIn == 3'h4 |=> stateReg == ST_ONE)
    else $error("match2 acted under code seven");
  chk_no_match: assert property (
    stateReg == ST_ONE && armReg && !armWr && !endSession && sysRst_n
    && matchIn == 3'h0 |=> stateReg == ST_ONE)
    else $error("state1 left without a match");
  chk_low_chan_two: assert property (
    stateReg == ST_ONE && armReg && !armWr && !endSession && sysRst_n
    && codeReg == 3'h6 && matchIn == 3'h5 |=> stateReg == ST_TWO)
    else $error("channel 0 did not beat channel 2");
  chk_align_lock: assert property (
    armReg && sysRst_n |=> $stable(alignReg))
    else $error("alignment changed while armed");
  chk_view_write: assert property (
    wrTake && regIdx == IDX_STATE_VIEW && viewReg == VIEW_STATE1
    && !armReg && sysRst_n
    |=> codeReg == $past(wbDatI[CODE_W-1:0]))
    else $error("state1 code write did not land");

  cov_wrap:  cover property (wrapEvt);
  cov_final: cover property (stateReg == ST_ONE ##1 stateReg == ST_FINAL);
  cov_stop:  cover property (endSession);
  cov_sys_keep: cover property (!sysRst_n && fullReg);
  cov_low_chan: cover property (stateReg == ST_ONE && matchIn == 3'h3);

endmodule : dtc_debug_trace

// file: verilog/dtc_pkg.sv
// shared constants of the trace count and state1 sequencer block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package dtc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_ONE = 8'h20;
  localparam logic [7:0] IDX_STATUS      = 8'h21;
  localparam logic [7:0] IDX_TRACE_CTRL  = 8'h22;
  localparam logic [7:0] IDX_TRACE_COUNT = 8'h26;
  localparam logic [7:0] IDX_STATE_VIEW  = 8'h27;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ARM_BIT      = 7;
  localparam int VIEW_LSB     = 0;
  localparam int ALIGN_BIT    = 0;
  localparam int FULL_BIT     = 7;
  localparam int CODE_W       = 3;
  localparam int COUNT_W      = 6;
  localparam int TRACE_LINES  = 64;
  localparam int LINE_W       = 20;

  // ----------------------------------------------------------------
  // reset values and view encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] VIEW_STATE1 = 2'h0;
  localparam logic [1:0] VIEW_STATE2 = 2'h1;
  localparam logic [1:0] VIEW_STATE3 = 2'h2;
  localparam logic [1:0] VIEW_MATCH  = 2'h3;
  localparam logic [CODE_W-1:0]  CODE_RESET  = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 6'h00;
  localparam logic ALIGN_END   = 1'b0;
  localparam logic ALIGN_BEGIN = 1'b1;

  typedef enum logic [2:0] {
    ST_DISARMED, ST_ONE, ST_TWO, ST_THREE, ST_FINAL
  } dtc_state_e;

endpackage : dtc_pkg

// file: verif/dtc_match_source.sv
// match channel and trace store source facing the debug block
// assumes a free-running mclk; the bench calls the tasks in turn
`timescale 1ns/1ps

module dtc_match_source (
  input  wire logic       mclk,
  output logic      [2:0] matchIn,
  output logic            lineStored
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  initial begin
    matchIn    = 3'h0;
    lineStored = 1'b0;
  end

  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  // only enabled channels are ever raised
  task automatic pulse_match(input logic [2:0] m);
    @(posedge mclk);
    matchIn <= m;
    @(posedge mclk);
    matchIn <= 3'h0;
  endtask : pulse_match

  // gap varies the store rate from prompt to slow
  task automatic store_lines(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      lineStored <= 1'b1;
      @(posedge mclk);
      lineStored <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask : store_lines
endmodule : dtc_match_source

// file: verif/dtc_debug_trace_tb_top.sv
// self-checking bench for the trace counter and state1 sequencer
// assumes the match source model and a one-cycle wishbone ack
`timescale 1ns/1ps

module dtc_debug_trace_tb_top;
  import dtc_pkg::*;
  logic             mclk, rst_n, sysRst_n, wbWe, wbCyc, wbStb, wbAck;
  logic             lineStored, armed, traceFull;
  logic [9:0]       wbAdr;
  logic [31:0]      wbDatI, wbDatO;
  logic [3:0]       wbSel;
  logic [2:0]       matchIn;
  logic [COUNT_W-1:0] lineCount;
  dtc_state_e       seqState;
  logic [7:0]       expQ[$], mskQ[$], e, mk;
  int               fails, n_compared, cycles, seed, n, k;
  // per code: target of ch2,ch1,ch0 in 3-bit fields, 0 = no effect
  localparam logic [8:0] SEQ_TBL [8] = '{9'h124, 9'h018, 9'h080, 9'h010,
                                         9'h01a, 9'h01c, 9'h0c2, 9'h012};

  dtc_debug_trace dtc_debug_trace_i (.mclk(mclk), .rst_n(rst_n),
    .sysRst_n(sysRst_n), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbWe(wbWe), .wbSel(wbSel), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbAck(wbAck), .matchIn(matchIn), .lineStored(lineStored),
    .armed(armed), .traceFull(traceFull), .lineCount(lineCount),
    .seqState(seqState));
  dtc_match_source dtc_match_source_i (.mclk(mclk), .matchIn(matchIn),
    .lineStored(lineStored));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] nextState(input logic [2:0] c,
                                           input logic [2:0] m);
    logic [2:0] r;
    r = 3'h1;
    for (int i = 2; i >= 0; i--)
      if (m[i] && SEQ_TBL[c][3*i +: 3] != 3'h0) r = SEQ_TBL[c][3*i +: 3];
    for (int i = 0; i < 3; i++)
      if (m[i] && SEQ_TBL[c][3*i +: 3] == 3'h4) r = 3'h4;
    return r;
  endfunction : nextState

  // request held until ack is sampled, then released for a cycle
  task automatic busOp(input logic we, input logic [7:0] idx,
                       input logic [7:0] d, input logic [7:0] m);
    if (!we) begin
      expQ.push_back(d & m);
      mskQ.push_back(m);
    end
    @(posedge mclk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= {idx, 2'h0};
    wbDatI <= we ? {24'h0, d} : 32'h0;
    do @(posedge mclk); while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : busOp

  task automatic pulseReset(input logic por);
    @(posedge mclk);
    if (por) rst_n <= 1'b0;
    else sysRst_n <= 1'b0;
    @(posedge mclk);
    rst_n    <= 1'b1;
    sysRst_n <= 1'b1;
  endtask : pulseReset

  // pin levels are read mid-cycle, well clear of the launching edge
  task automatic checkPins(input logic a, input logic f,
                           input logic [5:0] c, input logic [2:0] s);
    @(negedge mclk);
    n_compared++;
    if (armed !== a || traceFull !== f || lineCount !== c
        || 3'(seqState) !== s) begin
      fails++;
      $display("MISMATCH %0t pins %b %b %h %h", $time, armed, traceFull,
               lineCount, seqState);
    end
  endtask : checkPins

  task automatic tally_and_finish;
    if (expQ.size() != 0) fails++;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // clock, watchdog and read checker
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("MISMATCH %0t run timed out", $time);
      tally_and_finish();
    end else if (wbAck === 1'b1 && wbWe === 1'b0) begin
      n_compared++;
      if (expQ.size() == 0) begin
        fails++;
        $display("MISMATCH %0t unexpected read answer", $time);
      end else begin
        e  = expQ.pop_front();
        mk = mskQ.pop_front();
        if ((wbDatO[7:0] & mk) !== e || wbDatO[31:8] !== 24'h0) begin
          fails++;
          $display("MISMATCH %0t read %h want %h", $time, wbDatO[7:0], e);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, wbWe, wbCyc, wbStb, wbAdr, wbDatI} = '0;
    {sysRst_n, wbSel} = 5'h11;
    {fails, n_compared, cycles} = '0;
    seed = 42273;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    busOp(0, IDX_TRACE_COUNT, 8'h00, 8'hbf);
    busOp(0, IDX_STATE_VIEW, 8'h00, 8'hff);
    busOp(1, IDX_TRACE_COUNT, 8'hff, 8'h00);
    busOp(0, IDX_TRACE_COUNT, 8'h00, 8'hbf);
    busOp(1, IDX_STATE_VIEW, 8'hff, 8'h00);
    busOp(0, IDX_STATE_VIEW, 8'h07, 8'hff);
    busOp(1, IDX_CONTROL_ONE, 8'h01, 8'h00);
    busOp(0, IDX_STATE_VIEW, 8'h00, 8'hff);
    busOp(0, 8'h3f, 8'h00, 8'hff);
    $display("test registers done");
    for (int c = 0; c < 8; c++) for (int m = 1; m < 8; m++) begin
      busOp(1, IDX_CONTROL_ONE, 8'h00, 8'h00);
      busOp(1, IDX_STATE_VIEW, 8'(c), 8'h00);
      busOp(1, IDX_CONTROL_ONE, 8'h80, 8'h00);
      dtc_match_source_i.pulse_match(3'(m));
      busOp(0, IDX_STATUS, {5'h0, nextState(3'(c), 3'(m))}, 8'h07);
      checkPins(1'b1, 1'b0, 6'h00, nextState(3'(c), 3'(m)));
    end
    busOp(1, IDX_STATE_VIEW, 8'h02, 8'h00);
    busOp(1, IDX_CONTROL_ONE, 8'h00, 8'h00);
    busOp(0, IDX_STATE_VIEW, 8'h07, 8'hff);
    $display("test sequencer done");
    n = 1 + ($unsigned($random(seed)) % 62);
    busOp(1, IDX_TRACE_CTRL, {7'h0, ALIGN_END}, 8'h00);
    busOp(1, IDX_CONTROL_ONE, 8'h80, 8'h00);
    dtc_match_source_i.store_lines(n, $unsigned($random(seed)) % 3);
    busOp(0, IDX_TRACE_COUNT, 8'(n), 8'hbf);
    busOp(0, IDX_TRACE_COUNT, 8'(n), 8'hbf);
    pulseReset(1'b0);
    busOp(0, IDX_TRACE_COUNT, 8'(n), 8'hbf);
    busOp(0, IDX_CONTROL_ONE, 8'h00, 8'h80);
    busOp(1, IDX_CONTROL_ONE, 8'h80, 8'h00);
    busOp(0, IDX_TRACE_COUNT, 8'h00, 8'hbf);
    k = 1 + ($unsigned($random(seed)) % 8);
    dtc_match_source_i.store_lines(64 + k, 0);
    busOp(0, IDX_TRACE_COUNT, 8'h80 | 8'(k), 8'hbf);
    busOp(0, IDX_STATUS, 8'h80, 8'h80);
    checkPins(1'b1, 1'b1, 6'(k), 3'h1);
    pulseReset(1'b0);
    busOp(0, IDX_TRACE_COUNT, 8'h80 | 8'(k), 8'hbf);
    checkPins(1'b0, 1'b1, 6'(k), 3'h0);
    busOp(1, IDX_CONTROL_ONE, 8'h80, 8'h00);
    busOp(0, IDX_TRACE_COUNT, 8'h00, 8'hbf);
    $display("test end alignment done");
    busOp(1, IDX_CONTROL_ONE, 8'h00, 8'h00);
    busOp(1, IDX_TRACE_CTRL, {7'h0, ALIGN_BEGIN}, 8'h00);
    busOp(1, IDX_CONTROL_ONE, 8'h80, 8'h00);
    dtc_match_source_i.store_lines(64, 1);
    busOp(0, IDX_CONTROL_ONE, 8'h00, 8'h80);
    busOp(0, IDX_STATUS, 8'h80, 8'h87);
    checkPins(1'b0, 1'b1, 6'h00, 3'h0);
    dtc_match_source_i.store_lines(3, 0);
    busOp(0, IDX_TRACE_COUNT, 8'h80, 8'hbf);
    pulseReset(1'b1);
    busOp(0, IDX_TRACE_COUNT, 8'h00, 8'hbf);
    $display("test begin alignment done");
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule : dtc_debug_trace_tb_top
